// ===== rtl/oss_params.svh
// constants for the output step sequencer: timing, register map, field positions
`ifndef OSS_PARAMS_SVH
`define OSS_PARAMS_SVH
// clock and step timer tick
`define OSS_CLK_NS      25
`define OSS_TICK_NS     100000
`define OSS_TICK_CYC    (12'((`OSS_TICK_NS + `OSS_CLK_NS - 1) / `OSS_CLK_NS))
// register map
`define OSS_AW          14
`define OSS_ADDR_CTRL   14'h0000
`define OSS_ADDR_STAT   14'h0004
`define OSS_TBL_SEL     13
`define OSS_TBL_STEP    12:5
`define OSS_TBL_WORD    4:2
`define OSS_W_LVL       3'h0
`define OSS_W_FRQ       3'h1
`define OSS_W_CTL       3'h2
`define OSS_W_DUR       3'h3
`define OSS_W_JMP       3'h4
// step table fields
`define OSS_F_DC        15:0
`define OSS_F_AC        31:16
`define OSS_F_FRQ       23:0
`define OSS_F_WAVE      28:24
`define OSS_F_PHS       11:0
`define OSS_F_CODE      13:12
`define OSS_F_OP        15:14
`define OSS_F_END       17:16
`define OSS_F_PWAIT     18
`define OSS_F_JCNT      29:20
`define OSS_F_DUR       23:0
`define OSS_F_JTGT      7:0
`define OSS_F_BTGT      15:8
// control and status fields
`define OSS_C_START     0
`define OSS_C_HOLD      1
`define OSS_C_STOP      2
`define OSS_C_BRANCH    3
`define OSS_C_OUTEN     4
`define OSS_S_MODE      2:0
`define OSS_S_STEP      15:8
`define OSS_S_CODE      17:16
`define OSS_S_HEND      18
// bus answers and special step values
`define OSS_RESP_OK     2'h0
`define OSS_RESP_ERR    2'h2
`define OSS_STEP_NORM   8'h00
`define OSS_STEP_FIRST  8'h01
`define OSS_TGT_NONE    8'h00
`define OSS_JCNT_INF    10'h000
`endif

// ===== rtl/oss_pkg.sv
// types shared by the output step sequencer files
package oss_pkg;
	typedef enum logic [2:0] {
		OSS_IDLE = 3'b001,
		OSS_RUN  = 3'b010,
		OSS_HOLD = 3'b100
	} oss_mode_e;
	typedef enum logic [1:0] {
		OSS_OP_CONST = 2'h0,
		OSS_OP_RAMP  = 2'h1,
		OSS_OP_KEEP  = 2'h2
	} oss_op_e;
	typedef enum logic [1:0] {
		OSS_END_PROCEED_NEXT = 2'h0,
		OSS_END_HOLD         = 2'h1,
		OSS_END_IDLE         = 2'h2
	} oss_end_e;
	typedef logic signed [15:0] oss_lvl_t;
	typedef logic [23:0]        oss_frq_t;
	typedef logic signed [24:0] oss_ch_t;
endpackage : oss_pkg

// ===== rtl/oss_ramp.sv
// linear interpolation of one output channel between two end values
`timescale 1ns/100ps
module oss_ramp
	import oss_pkg::*;
(
	input  wire oss_pkg::oss_ch_t i_from,
	input  wire oss_pkg::oss_ch_t i_to,
	input  wire logic [23:0]      i_elapsed,
	input  wire logic [23:0]      i_dur,
	output oss_pkg::oss_ch_t      o_val
);
	logic signed [25:0] delta;
	logic signed [50:0] prod;
	logic signed [50:0] quot;

	// from + (to - from) * elapsed / duration, end value once duration is zero
	always_comb begin
		delta = 26'(i_to) - 26'(i_from);
		prod  = 51'(delta) * $signed({27'h0, i_elapsed});
		quot  = '0;
		if (i_dur != 24'h000000) begin
			quot = prod / $signed({27'h0, i_dur});
		end
		o_val = (i_dur == 24'h000000) ? i_to : 25'(51'(i_from) + quot);
	end
endmodule : oss_ramp

// ===== rtl/oss_seq_top.sv
// output step sequencer: step table, mode machine, step timer and AXI4-Lite slave
// How it works
// RULE1: constant step drives exactly the step's stored output values.
// RULE2: ramp step moves linearly from previous end value to target over duration.
// RULE3: keep step holds the values reached at the end of the previous step.
// RULE4: keep step ignores all stored output values, wave and phase.
// RULE5: each step stores wave select, DC, AC, frequency, start phase and step code.
// RULE6: each step stores an end action: proceed_next, hold or idle.
// RULE7: jump target zero goes to next step, 1 to 255 goes to that step.
// RULE8: jump count 1 to 999 limits jumps, zero repeats without limit.
// RULE9: branch request goes to the step's branch target, zero keeps running.
// RULE10: start in idle begins at step 1, then follows the transitions.
// RULE11: a step ends when its programmed duration has elapsed.
// RULE12: with phase wait, step ends at first phase zero after the duration.
// RULE13: end action takes priority over the jump target.
// RULE14: idle during normal output, run while a sequence executes.
// RULE15: hold pauses the sequence and freezes the outputs.
// RULE16: end actions hold and idle switch the mode themselves.
// RULE17: normal output uses step 0 of the same table while idle.
// RULE18: step code of the running step is output, zero while idle.
// RULE19: start in hold resumes; after an end-action hold it goes via the jump.
// RULE20: stop goes straight to idle and keeps the present output values.
// RULE21: each step has its own jump counter; count N runs the loop N+1 times.
// RULE22: duration counts 0.1 ms ticks; phase wait uses the phase-wrap strobe.
// RULE23: requests are one-cycle pulses, ignored while output is disabled.
`timescale 1ns/100ps
`include "oss_params.svh"
module oss_seq_top (
	input  wire logic                 I_REF_CLK,
	input  wire logic                 I_RST,
	input  wire logic                 I_AWVALID,
	input  wire logic [`OSS_AW-1:0]   I_AWADDR,
	output logic                      O_AWREADY,
	input  wire logic                 I_WVALID,
	input  wire logic [31:0]          I_WDATA,
	input  wire logic [3:0]           I_WSTRB,
	output logic                      O_WREADY,
	output logic                      O_BVALID,
	output logic [1:0]                O_BRESP,
	input  wire logic                 I_BREADY,
	input  wire logic                 I_ARVALID,
	input  wire logic [`OSS_AW-1:0]   I_ARADDR,
	output logic                      O_ARREADY,
	output logic                      O_RVALID,
	output logic [31:0]               O_RDATA,
	output logic [1:0]                O_RRESP,
	input  wire logic                 I_RREADY,
	input  wire logic                 I_PHASE_WRAP,
	output oss_pkg::oss_lvl_t         O_DC,
	output oss_pkg::oss_lvl_t         O_AC,
	output oss_pkg::oss_frq_t         O_FREQ,
	output logic [4:0]                O_WAVE,
	output logic [11:0]               O_PHASE,
	output logic [1:0]                O_CODE,
	output oss_pkg::oss_mode_e        O_MODE,
	output logic [7:0]                O_STEP
);
	import oss_pkg::*;

	oss_lvl_t    t_dc [256];
	oss_lvl_t    t_ac [256];
	oss_frq_t    t_frq [256];
	logic [4:0]  t_wave [256];
	logic [11:0] t_phs [256];
	logic [1:0]  t_code [256];
	logic [1:0]  t_op [256];
	logic [1:0]  t_end [256];
	logic        t_pwait [256];
	logic [9:0]  t_jcnt [256];
	logic [23:0] t_dur [256];
	logic [7:0]  t_jtgt [256];
	logic [7:0]  t_btgt [256];
	logic [9:0]  jcnt [256];
	logic              aw_full, w_full, wr_go, tbl_we;
	logic [`OSS_AW-1:0] aw_addr;
	logic [31:0]       w_data, wr_old, wr_new;
	logic [3:0]        w_strb;
	logic [7:0]        wr_step;
	logic [2:0]        wr_word;
	logic              out_en, req_start, req_hold, req_stop, req_branch;
	oss_mode_e         mode, next_mode;
	logic [7:0]        cur, next_cur, jump_dest;
	logic              held_end, next_held_end, enter, advance, jc_inc, jc_clr;
	logic              save_norm, step_first;
	logic [11:0]       tick_cnt;
	logic [23:0]       elapsed;
	logic              dur_hit, step_done;
	logic              do_start, do_resume, do_hold, do_stop, do_branch;
	oss_ch_t           from_ch [3];
	oss_ch_t           to_ch [3];
	oss_ch_t           ramp_ch [3];

	////////////////////////////////////////////////////////////////////////
	// register bus

	// table word as software sees it
	function automatic logic [31:0] tbl_word(input logic [7:0] s, input logic [2:0] w);
		logic [31:0] r;
		r = '0;
		case (w)
			`OSS_W_LVL: begin
				r[`OSS_F_DC] = t_dc[s];
				r[`OSS_F_AC] = t_ac[s];
			end
			`OSS_W_FRQ: begin
				r[`OSS_F_FRQ]  = t_frq[s];
				r[`OSS_F_WAVE] = t_wave[s];
			end
			`OSS_W_CTL: begin
				r[`OSS_F_PHS]   = t_phs[s];
				r[`OSS_F_CODE]  = t_code[s];
				r[`OSS_F_OP]    = t_op[s];
				r[`OSS_F_END]   = t_end[s];
				r[`OSS_F_PWAIT] = t_pwait[s];
				r[`OSS_F_JCNT]  = t_jcnt[s];
			end
			`OSS_W_DUR: r[`OSS_F_DUR] = t_dur[s];
			`OSS_W_JMP: begin
				r[`OSS_F_JTGT] = t_jtgt[s];
				r[`OSS_F_BTGT] = t_btgt[s];
			end
			default: r = '0;
		endcase
		return r;
	endfunction : tbl_word

	// write happens once address and data are both held
	assign wr_go   = aw_full & w_full & ~O_BVALID;
	assign tbl_we  = wr_go & aw_addr[`OSS_TBL_SEL];
	assign wr_step = aw_addr[`OSS_TBL_STEP];
	assign wr_word = aw_addr[`OSS_TBL_WORD];

	// byte-lane merge of the written word
	always_comb begin
		wr_old = tbl_word(wr_step, wr_word);
		for (int b = 0; b < 4; b++) begin
			wr_new[b*8 +: 8] = w_strb[b] ? w_data[b*8 +: 8] : wr_old[b*8 +: 8];
		end
	end

	// write channels, taken in either order, answered after both
	always_ff @(posedge I_REF_CLK or posedge I_RST) begin
		if (I_RST) begin
			aw_full   <= 1'b0;
			w_full    <= 1'b0;
			aw_addr   <= '0;
			w_data    <= '0;
			w_strb    <= '0;
			O_AWREADY <= 1'b1;
			O_WREADY  <= 1'b1;
			O_BVALID  <= 1'b0;
			O_BRESP   <= `OSS_RESP_OK;
		end else begin
			if (I_AWVALID && O_AWREADY) begin
				aw_full   <= 1'b1;
				aw_addr   <= I_AWADDR;
				O_AWREADY <= 1'b0;
			end
			if (I_WVALID && O_WREADY) begin
				w_full   <= 1'b1;
				w_data   <= I_WDATA;
				w_strb   <= I_WSTRB;
				O_WREADY <= 1'b0;
			end
			if (wr_go) begin
				aw_full  <= 1'b0;
				w_full   <= 1'b0;
				O_BVALID <= 1'b1;
				O_BRESP  <= (aw_addr[`OSS_TBL_SEL] || aw_addr == `OSS_ADDR_CTRL ||
					aw_addr == `OSS_ADDR_STAT) ? `OSS_RESP_OK : `OSS_RESP_ERR;
			end
			if (O_BVALID && I_BREADY) begin
				O_BVALID  <= 1'b0;
				O_AWREADY <= 1'b1;
				O_WREADY  <= 1'b1;
			end
		end
	end

	// control register: enable level and self-clearing request pulses
	always_ff @(posedge I_REF_CLK or posedge I_RST) begin
		if (I_RST) begin
			out_en     <= 1'b0;
			req_start  <= 1'b0;
			req_hold   <= 1'b0;
			req_stop   <= 1'b0;
			req_branch <= 1'b0;
		end else begin
			req_start  <= 1'b0;
			req_hold   <= 1'b0;
			req_stop   <= 1'b0;
			req_branch <= 1'b0;
			if (wr_go && aw_addr == `OSS_ADDR_CTRL && w_strb[0]) begin
				out_en     <= w_data[`OSS_C_OUTEN];
				req_start  <= w_data[`OSS_C_START];  // RULE23
				req_hold   <= w_data[`OSS_C_HOLD];
				req_stop   <= w_data[`OSS_C_STOP];
				req_branch <= w_data[`OSS_C_BRANCH];
			end
		end
	end

	// read channel, answer one cycle after the address is taken
	always_ff @(posedge I_REF_CLK or posedge I_RST) begin
		if (I_RST) begin
			O_ARREADY <= 1'b1;
			O_RVALID  <= 1'b0;
			O_RDATA   <= '0;
			O_RRESP   <= `OSS_RESP_OK;
		end else if (I_ARVALID && O_ARREADY) begin
			O_ARREADY <= 1'b0;
			O_RVALID  <= 1'b1;
			O_RRESP   <= `OSS_RESP_OK;
			O_RDATA   <= '0;
			if (I_ARADDR[`OSS_TBL_SEL]) begin
				O_RDATA <= tbl_word(I_ARADDR[`OSS_TBL_STEP], I_ARADDR[`OSS_TBL_WORD]);
			end else if (I_ARADDR == `OSS_ADDR_CTRL) begin
				O_RDATA[`OSS_C_OUTEN] <= out_en;
			end else if (I_ARADDR == `OSS_ADDR_STAT) begin
				O_RDATA[`OSS_S_MODE] <= mode;
				O_RDATA[`OSS_S_STEP] <= cur;
				O_RDATA[`OSS_S_CODE] <= O_CODE;
				O_RDATA[`OSS_S_HEND] <= held_end;
			end else begin
				O_RRESP <= `OSS_RESP_ERR;
			end
		end else if (O_RVALID && I_RREADY) begin
			O_RVALID  <= 1'b0;
			O_ARREADY <= 1'b1;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// step table and per-step jump counters

	for (genvar e = 0; e < 256; e++) begin : g_ent
		// stored step parameters; step 0 is the normal-output step
		always_ff @(posedge I_REF_CLK or posedge I_RST) begin
			if (I_RST) begin
				t_dc[e] <= '0; t_ac[e] <= '0; t_frq[e] <= '0; t_wave[e] <= '0;
				t_phs[e] <= '0; t_code[e] <= '0; t_op[e] <= '0; t_end[e] <= '0;
				t_pwait[e] <= 1'b0; t_jcnt[e] <= '0; t_dur[e] <= '0;
				t_jtgt[e] <= '0; t_btgt[e] <= '0;
			end else if (save_norm && e == 0) begin
				t_dc[e]   <= O_DC;  // RULE20
				t_ac[e]   <= O_AC;
				t_frq[e]  <= O_FREQ;
				t_wave[e] <= O_WAVE;
				t_phs[e]  <= O_PHASE;
			end else if (tbl_we && wr_step == 8'(e)) begin
				unique case (wr_word)  // RULE5 RULE6
					`OSS_W_LVL: begin
						t_dc[e] <= wr_new[`OSS_F_DC];
						t_ac[e] <= wr_new[`OSS_F_AC];
					end
					`OSS_W_FRQ: begin
						t_frq[e]  <= wr_new[`OSS_F_FRQ];
						t_wave[e] <= wr_new[`OSS_F_WAVE];
					end
					`OSS_W_CTL: begin
						t_phs[e]   <= wr_new[`OSS_F_PHS];
						t_code[e]  <= wr_new[`OSS_F_CODE];
						t_op[e]    <= wr_new[`OSS_F_OP];
						t_end[e]   <= wr_new[`OSS_F_END];
						t_pwait[e] <= wr_new[`OSS_F_PWAIT];
						t_jcnt[e]  <= wr_new[`OSS_F_JCNT];
					end
					`OSS_W_DUR: t_dur[e] <= wr_new[`OSS_F_DUR];
					`OSS_W_JMP: begin
						t_jtgt[e] <= wr_new[`OSS_F_JTGT];
						t_btgt[e] <= wr_new[`OSS_F_BTGT];
					end
					default: t_dur[e] <= t_dur[e];
				endcase
			end
		end

		// own jump counter, so nested loops keep separate counts
		always_ff @(posedge I_REF_CLK or posedge I_RST) begin
			if (I_RST) begin
				jcnt[e] <= '0;
			end else if (mode == OSS_IDLE) begin
				jcnt[e] <= '0;
			end else if (jc_clr && cur == 8'(e)) begin
				jcnt[e] <= '0;  // RULE21
			end else if (jc_inc && cur == 8'(e)) begin
				jcnt[e] <= jcnt[e] + 10'h001;
			end
		end
	end

	////////////////////////////////////////////////////////////////////////
	// mode machine

	// accepted requests, only with output enabled
	assign do_start  = req_start & out_en & (mode == OSS_IDLE);
	assign do_resume = req_start & out_en & (mode == OSS_HOLD);
	assign do_hold   = req_hold & out_en & (mode == OSS_RUN);
	assign do_stop   = req_stop & out_en & (mode != OSS_IDLE);
	assign do_branch = req_branch & out_en & (mode == OSS_RUN) &
		(t_btgt[cur] != `OSS_TGT_NONE);  // RULE9
	assign dur_hit   = elapsed >= t_dur[cur];  // RULE11
	assign step_done = (mode == OSS_RUN) & dur_hit & (~t_pwait[cur] | I_PHASE_WRAP);  // RULE12 RULE22

	// destination after a finished step, with jump count bookkeeping
	always_comb begin
		jump_dest = cur + 8'h01;
		jc_inc    = 1'b0;
		jc_clr    = 1'b0;
		if (t_jtgt[cur] != `OSS_TGT_NONE) begin  // RULE7
			if (t_jcnt[cur] == `OSS_JCNT_INF) begin  // RULE8
				jump_dest = t_jtgt[cur];
			end else if (jcnt[cur] < t_jcnt[cur]) begin
				jump_dest = t_jtgt[cur];
				jc_inc    = advance;
			end else begin
				jc_clr    = advance;
			end
		end
	end

	// next mode and step; stop wins over hold, hold over branch and step end
	always_comb begin
		next_mode     = mode;
		next_cur      = cur;
		next_held_end = held_end;
		enter         = 1'b0;
		advance       = 1'b0;
		unique case (mode)
			OSS_IDLE: begin
				if (do_start) begin
					next_mode = OSS_RUN;  // RULE10 RULE14
					next_cur  = `OSS_STEP_FIRST;
					enter     = 1'b1;
				end
			end
			OSS_RUN: begin
				if (do_stop) begin
					next_mode = OSS_IDLE;  // RULE20
				end else if (do_hold) begin
					next_mode     = OSS_HOLD;  // RULE15
					next_held_end = 1'b0;
				end else if (do_branch) begin
					next_cur = t_btgt[cur];
					enter    = 1'b1;
				end else if (step_done) begin
					unique case (t_end[cur])  // RULE13 RULE16
						OSS_END_HOLD: begin
							next_mode     = OSS_HOLD;
							next_held_end = 1'b1;
						end
						OSS_END_IDLE: next_mode = OSS_IDLE;
						default: begin
							advance = 1'b1;
							enter   = jump_dest != `OSS_STEP_NORM;
							next_cur = jump_dest;
							if (jump_dest == `OSS_STEP_NORM) begin
								next_mode = OSS_IDLE;
							end
						end
					endcase
				end
			end
			OSS_HOLD: begin
				if (do_stop) begin
					next_mode = OSS_IDLE;
				end else if (do_resume) begin
					next_mode     = OSS_RUN;  // RULE19
					next_held_end = 1'b0;
					if (held_end) begin
						advance  = 1'b1;
						enter    = jump_dest != `OSS_STEP_NORM;
						next_cur = jump_dest;
						if (jump_dest == `OSS_STEP_NORM) begin
							next_mode = OSS_IDLE;
						end
					end
				end
			end
		endcase
		if (next_mode == OSS_IDLE) begin
			next_cur = `OSS_STEP_NORM;  // RULE17
		end
	end
	assign save_norm = (mode != OSS_IDLE) && (next_mode == OSS_IDLE);

	// mode, step number and end-hold marker
	always_ff @(posedge I_REF_CLK or posedge I_RST) begin
		if (I_RST) begin
			mode     <= OSS_IDLE;
			cur      <= `OSS_STEP_NORM;
			held_end <= 1'b0;
			O_MODE   <= OSS_IDLE;
			O_STEP   <= `OSS_STEP_NORM;
		end else begin
			mode     <= next_mode;
			cur      <= next_cur;
			held_end <= next_held_end;
			O_MODE   <= next_mode;
			O_STEP   <= next_cur;
		end
	end

	// step timer in 0.1 ms ticks, frozen outside run
	always_ff @(posedge I_REF_CLK or posedge I_RST) begin
		if (I_RST) begin
			tick_cnt <= '0;
			elapsed  <= '0;
		end else if (enter) begin
			tick_cnt <= '0;
			elapsed  <= '0;
		end else if (mode == OSS_RUN && !dur_hit) begin
			if (tick_cnt == `OSS_TICK_CYC - 12'h001) begin
				tick_cnt <= '0;  // RULE22
				elapsed  <= elapsed + 24'h000001;
			end else begin
				tick_cnt <= tick_cnt + 12'h001;
			end
		end
	end

	////////////////////////////////////////////////////////////////////////
	// output values

	// ramp start values, taken one edge after entry so the old step's last value is in
	always_ff @(posedge I_REF_CLK or posedge I_RST) begin
		if (I_RST) begin
			step_first <= 1'b0;
			for (int c = 0; c < 3; c++) begin
				from_ch[c] <= '0;
			end
		end else begin
			step_first <= enter;
			if (step_first) begin
				from_ch[0] <= 25'(O_DC);
				from_ch[1] <= 25'(O_AC);
				from_ch[2] <= $signed({1'b0, O_FREQ});
			end
		end
	end
	assign to_ch[0] = 25'(t_dc[cur]);
	assign to_ch[1] = 25'(t_ac[cur]);
	assign to_ch[2] = $signed({1'b0, t_frq[cur]});

	// one interpolator per channel
	for (genvar c = 0; c < 3; c++) begin : g_ramp
		oss_ramp u_ramp (
			.i_from    (from_ch[c]),
			.i_to      (to_ch[c]),
			.i_elapsed (elapsed),
			.i_dur     (t_dur[cur]),
			.o_val     (ramp_ch[c])
		);
	end

	// outputs follow step 0 in idle with code zero, the step type in run; frozen in hold and a step's first cycle
	always_ff @(posedge I_REF_CLK or posedge I_RST) begin
		if (I_RST) begin
			O_DC <= '0; O_AC <= '0; O_FREQ <= '0;
			O_WAVE <= '0; O_PHASE <= '0; O_CODE <= '0;
		end else if (mode == OSS_IDLE) begin
			O_DC    <= t_dc[`OSS_STEP_NORM];  // RULE17
			O_AC    <= t_ac[`OSS_STEP_NORM];
			O_FREQ  <= t_frq[`OSS_STEP_NORM];
			O_WAVE  <= t_wave[`OSS_STEP_NORM];
			O_PHASE <= t_phs[`OSS_STEP_NORM];
			O_CODE  <= '0;  // RULE18
		end else if (mode == OSS_RUN && !step_first && !save_norm) begin  // RULE3 RULE4
			O_CODE <= t_code[cur];
			if (t_op[cur] == OSS_OP_CONST) begin
				O_DC    <= t_dc[cur];  // RULE1
				O_AC    <= t_ac[cur];
				O_FREQ  <= t_frq[cur];
				O_WAVE  <= t_wave[cur];
				O_PHASE <= t_phs[cur];
			end else if (t_op[cur] == OSS_OP_RAMP) begin
				O_DC    <= 16'(ramp_ch[0]);  // RULE2
				O_AC    <= 16'(ramp_ch[1]);
				O_FREQ  <= ramp_ch[2][23:0];
				O_WAVE  <= t_wave[cur];
				O_PHASE <= t_phs[cur];
			end
		end
	end

	////////////////////////////////////////////////////////////////////////
	// checks

	chk_const_level: assert property (@(posedge I_REF_CLK) disable iff (I_RST) // RULE1
		(mode == OSS_RUN && !step_first && !save_norm && t_op[cur] == OSS_OP_CONST)
		|=> (O_DC == $past(t_dc[cur]) && O_FREQ == $past(t_frq[cur])))
		else $error("constant step output differs from stored value");
	chk_keep_frozen: assert property (@(posedge I_REF_CLK) disable iff (I_RST) // RULE3
		(mode == OSS_RUN && t_op[cur] == OSS_OP_KEEP)
		|=> ($stable(O_DC) && $stable(O_WAVE) && $stable(O_PHASE)))
		else $error("keep step changed the output");
	chk_start_first: assert property (@(posedge I_REF_CLK) disable iff (I_RST) // RULE10
		do_start |=> (cur == `OSS_STEP_FIRST && mode == OSS_RUN))
		else $error("start did not begin at step 1");
	chk_stop_idle: assert property (@(posedge I_REF_CLK) disable iff (I_RST) // RULE20
		do_stop |=> (mode == OSS_IDLE && t_dc[`OSS_STEP_NORM] == $past(O_DC)))
		else $error("stop did not reach idle with values kept");
	chk_hold_freeze: assert property (@(posedge I_REF_CLK) disable iff (I_RST) // RULE15
		(mode == OSS_HOLD && !do_stop && !do_resume) |=> ($stable(O_AC) && $stable(O_FREQ)))
		else $error("output moved in hold");
	chk_end_first: assert property (@(posedge I_REF_CLK) disable iff (I_RST) // RULE13
		(step_done && !req_stop && !req_hold && !req_branch && t_end[cur] == OSS_END_HOLD)
		|=> (mode == OSS_HOLD && held_end))
		else $error("hold end action not taken");
	chk_duration_run: assert property (@(posedge I_REF_CLK) disable iff (I_RST) // RULE11
		(mode == OSS_RUN && !dur_hit && !do_stop && !do_hold && !do_branch)
		|=> (mode == OSS_RUN && cur == $past(cur)))
		else $error("step ended before its duration");
	chk_phase_wait: assert property (@(posedge I_REF_CLK) disable iff (I_RST) // RULE12
		(mode == OSS_RUN && dur_hit && t_pwait[cur] && !I_PHASE_WRAP &&
		!do_stop && !do_hold && !do_branch) |=> (cur == $past(cur) && mode == OSS_RUN))
		else $error("step ended before phase zero");
	chk_idle_code: assert property (@(posedge I_REF_CLK) disable iff (I_RST) // RULE18
		(mode == OSS_IDLE) |=> (O_CODE == 2'h0))
		else $error("step code not zero in idle");
	chk_branch_move: assert property (@(posedge I_REF_CLK) disable iff (I_RST) // RULE9
		(do_branch && !do_stop && !do_hold) |=> (cur == $past(t_btgt[cur]) && mode == OSS_RUN))
		else $error("branch did not reach its target");
	chk_disabled_ignore: assert property (@(posedge I_REF_CLK) disable iff (I_RST) // RULE23
		(mode == OSS_IDLE && !out_en) |=> (mode == OSS_IDLE))
		else $error("request taken with output disabled");
endmodule : oss_seq_top

// ===== tb/tb_top.sv
// self-checking bench for the output step sequencer
`timescale 1ns/100ps
`include "oss_params.svh"
module tb_top;
	import oss_pkg::*;
	logic        clk, rst, awv, wv, bry, arv, rry, pw;
	logic [13:0] awa, ara;
	logic [31:0] wd, rdat, v0, v1, v2;
	logic [1:0]  rsp, bsp;
	logic [31:0] mdl [int];
	int          failures, n_tests, mid;
	oss_lvl_t    o_dc, o_ac;
	oss_frq_t    o_freq;
	logic [4:0]  o_wave;
	logic [11:0] o_phase;
	logic [1:0]  o_code, bresp, rresp;
	oss_mode_e   o_mode;
	logic [7:0]  o_step;
	logic        awrdy, wrdy, bvld, arrdy, rvld;
	logic [31:0] o_rdata;
	oss_seq_top dut (.I_REF_CLK(clk), .I_RST(rst), .I_AWVALID(awv), .I_AWADDR(awa),
		.O_AWREADY(awrdy), .I_WVALID(wv), .I_WDATA(wd), .I_WSTRB(4'hf), .O_WREADY(wrdy),
		.O_BVALID(bvld), .O_BRESP(bresp), .I_BREADY(bry), .I_ARVALID(arv),
		.I_ARADDR(ara), .O_ARREADY(arrdy), .O_RVALID(rvld), .O_RDATA(o_rdata),
		.O_RRESP(rresp), .I_RREADY(rry), .I_PHASE_WRAP(pw), .O_DC(o_dc), .O_AC(o_ac),
		.O_FREQ(o_freq), .O_WAVE(o_wave), .O_PHASE(o_phase), .O_CODE(o_code),
		.O_MODE(o_mode), .O_STEP(o_step));
	////////////////////////////////////////////////////////////////////////////////
	// byte address of one step table word
	function automatic logic [13:0] ta(input int s, input int w);
		return 14'(32'h2000 + s * 32 + w * 4);
	endfunction : ta
	// compare and count
	task automatic chk(input string n, input logic [31:0] e, input logic [31:0] s);
		n_tests++;
		if (e !== s) begin
			failures++;
			$display("mismatch %s expected %h seen %h", n, e, s);
		end
	endtask : chk
	// one bus write, address and data offered together, model updated
	task automatic wr(input logic [13:0] a, input logic [31:0] d);
		logic da, dw;
		da = 0;
		dw = 0;
		mdl[a] = d;
		@(posedge clk);
		awv <= 1; wv <= 1; awa <= a; wd <= d; bry <= 1;
		while (!(da && dw)) begin
			@(posedge clk);
			if (awrdy === 1'b1) da = 1;
			if (wrdy === 1'b1) dw = 1;
			if (da) awv <= 0;
			if (dw) wv <= 0;
		end
		do @(posedge clk); while (bvld !== 1'b1);
		bsp = bresp;
		bry <= 0;
	endtask : wr
	// one bus read
	task automatic rd(input logic [13:0] a);
		@(posedge clk);
		arv <= 1; ara <= a; rry <= 1;
		do @(posedge clk); while (arrdy !== 1'b1);
		arv <= 0;
		do @(posedge clk); while (rvld !== 1'b1);
		rdat = o_rdata;
		rsp = rresp;
		rry <= 0;
	endtask : rd
	// wait for a mode under a bound, then compare
	task automatic wmode(input oss_mode_e m);
		int k;
		for (k = 0; k < 6000 && o_mode !== m; k++) @(negedge clk);
		chk("mode", 32'(m), 32'(o_mode));
	endtask : wmode
	task automatic conclude();
		$display("comparisons %0d failures %0d", n_tests, failures);
		if (failures == 0 && n_tests > 0) $display("SIMULATION PASSED");
		else $display("SIMULATION FAILED");
		$finish;
	endtask : conclude
	////////////////////////////////////////////////////////////////////////////////
	// clock
	initial begin
		clk = 0;
		forever #12.5 clk = ~clk;
	end
	// watchdog
	initial begin
		repeat (40000) @(posedge clk);
		failures++;
		conclude();
	end
	// main sequence
	initial begin
		rst = 1;
		{awv, wv, bry, arv, rry, awa, ara, wd, pw} = '0;
		failures = 0;
		n_tests = 0;
		void'($urandom(62953));
		v0 = $urandom; v1 = $urandom; v2 = $urandom;
		repeat (12) @(posedge clk);
		rst <= 0;
		@(negedge clk);
		chk("reset mode", 32'(OSS_IDLE), 32'(o_mode));
		chk("reset step", 0, 32'(o_step));
		wr(ta(0, 0), v0);
		chk("write resp", 32'(`OSS_RESP_OK), 32'(bsp));
		wr(ta(0, 2), 32'h0000_2000);
		repeat (2) @(negedge clk);
		chk("idle dc", 32'(v0[15:0]), {16'h0, o_dc});
		chk("idle code", 0, 32'(o_code));
		rd(ta(0, 0));
		chk("table word", mdl[ta(0, 0)], rdat);
		rd(14'h1000);
		chk("unmapped resp", 32'(`OSS_RESP_ERR), 32'(rsp));
		chk("unmapped data", 0, rdat);
		wr(14'h1000, 0);
		chk("unmapped wresp", 32'(`OSS_RESP_ERR), 32'(bsp));
		wr(ta(1, 0), v1);
		wr(ta(1, 1), v0);
		wr(ta(1, 2), 32'h0001_3abc);
		wr(ta(1, 3), 32'h1);
		wr(ta(2, 0), v2);
		wr(ta(2, 3), 32'h1);
		wr(`OSS_ADDR_CTRL, 32'h1);
		repeat (4) @(negedge clk);
		chk("start disabled", 32'(OSS_IDLE), 32'(o_mode));
		wr(`OSS_ADDR_CTRL, 32'h11);
		wmode(OSS_RUN);
		chk("first step", 1, 32'(o_step));
		repeat (2) @(negedge clk);
		chk("const ac", 32'(v1[31:16]), {16'h0, o_ac});
		chk("const freq", 32'(v0[23:0]), 32'(o_freq));
		chk("const wave", 32'(v0[28:24]), 32'(o_wave));
		chk("const phase", 32'h0000_0abc, 32'(o_phase));
		chk("run code", 3, 32'(o_code));
		wmode(OSS_HOLD);
		chk("held dc", 32'(v1[15:0]), {16'h0, o_dc});
		wr(`OSS_ADDR_CTRL, 32'h11);
		wmode(OSS_RUN);
		chk("resume step", 2, 32'(o_step));
		repeat (2) @(negedge clk);
		wr(`OSS_ADDR_CTRL, 32'h14);
		wmode(OSS_IDLE);
		repeat (2) @(negedge clk);
		chk("stop dc", 32'(v2[15:0]), {16'h0, o_dc});
		chk("stop step", 0, 32'(o_step));
		wr(ta(1, 2), 32'h0000_5000);
		wr(ta(1, 3), 32'h2);
		wr(ta(2, 2), 32'h0004_8000);
		wr(ta(2, 3), 32'h0);
		wr(ta(3, 2), 32'h0010_0000);
		wr(ta(3, 4), 32'h2);
		wr(ta(4, 3), 32'h1);
		wr(ta(4, 4), 32'h0000_0600);
		wr(ta(6, 0), ~v0);
		wr(ta(6, 2), 32'h0002_0000);
		wr(ta(6, 3), 32'h1);
		wr(`OSS_ADDR_CTRL, 32'h11);
		wmode(OSS_RUN);
		repeat (6000) @(negedge clk);
		mid = $signed(v2[15:0]) + ($signed(v1[15:0]) - $signed(v2[15:0])) / 2;
		chk("ramp dc", {16'h0, 16'(mid)}, {16'h0, o_dc});
		repeat (3000) @(negedge clk);
		chk("wait step", 2, 32'(o_step));
		chk("keep dc", 32'(v1[15:0]), {16'h0, o_dc});
		for (int j = 0; j < 2; j++) begin
			@(posedge clk) pw <= 1;
			@(posedge clk) pw <= 0;
			repeat (4) @(negedge clk);
			chk("loop step", 2 + 2 * j, 32'(o_step));
		end
		wr(`OSS_ADDR_CTRL, 32'h18);
		repeat (2) @(negedge clk);
		chk("branch step", 6, 32'(o_step));
		wmode(OSS_IDLE);
		repeat (2) @(negedge clk);
		chk("end idle dc", {16'h0, ~v0[15:0]}, {16'h0, o_dc});
		conclude();
	end
endmodule : tb_top
